// ---- design/ucil_defines.vh ----
// ucil_defines.vh: register offsets, field positions, reset values and counts for the channel interrupt logic
// assumes: included by bare name from the design, checker and bench files of this block only
`ifndef UCIL_DEFINES_VH
`define UCIL_DEFINES_VH

// register offsets (4-bit channel address)
`define UCIL_ADDR_RHR 4'h0
`define UCIL_ADDR_IER 4'h1
`define UCIL_ADDR_ISR 4'h2
`define UCIL_ADDR_FCR 4'h2
`define UCIL_ADDR_MCR 4'h4
`define UCIL_ADDR_LSR 4'h5
`define UCIL_ADDR_MSR 4'h6
`define UCIL_ADDR_EFR 4'h9
`define UCIL_ADDR_RX_FIFO_LEVEL_COUNT 4'hB
`define UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS 4'hC
`define UCIL_ADDR_STOP_CHAR_SECOND 4'hD
`define UCIL_ADDR_RESUME_CHAR_FIRST 4'hE
`define UCIL_ADDR_RESUME_CHAR_SECOND 4'hF

// field positions
`define UCIL_EFR_UNLOCK 4
`define UCIL_EFR_AUTO_RTS 6
`define UCIL_EFR_AUTO_CTS 7
`define UCIL_MCR_FLOW_SEL 2
`define UCIL_FCR_ENABLE 0

// reset values
`define UCIL_IER_RST 8'h00
`define UCIL_CHAR_RST 8'h00
`define UCIL_TRG_RST 8'h01

// interrupt source codes, bits 5..0
`define UCIL_CODE_LSR 6'h06
`define UCIL_CODE_RECEIVE_READY_EVENT 6'h04
`define UCIL_CODE_RXTO 6'h0C
`define UCIL_CODE_TRANSMIT_READY_EVENT 6'h02
`define UCIL_CODE_MSR 6'h00
`define UCIL_CODE_FLOW_CHAR_DETECT_FLAGS 6'h10
`define UCIL_CODE_FLOW 6'h20
`define UCIL_CODE_NONE 6'h01

// time-out delay: 4 characters plus 12 bits
`define UCIL_TO_CHARS 10'h004
`define UCIL_TO_BITS 10'h00C

`endif

// ---- design/ucil_chan_int.v ----
// ucil_chan_int.v: per-channel interrupt enable, priority, source code and clearing logic
// assumes: receiver, transmitter, fifo and flow engines outside supply levels and one-cycle events;
// host register accesses arrive as one-cycle read/write strobes synchronous to i_clk_sys
`timescale 1ns/100ps
`include "ucil_defines.vh"

module ucil_chan_int (
  // clock and reset
  input wire i_clk_sys,
  input wire i_srst,
  input wire i_ce,
  // host register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // configuration owned by the lower register map
  input wire [7:0] i_enhanced_function_control,
  input wire [7:0] i_modem_control,
  input wire i_auto_rs485,
  input wire [7:0] i_rx_trigger_level,
  input wire [7:0] i_tx_trigger_level,
  input wire [3:0] i_bit_clk_per_char,
  // receiver side
  input wire [7:0] i_rx_fifo_level,
  input wire i_rx_char_in,
  input wire i_rx_overrun,
  input wire [2:0] i_rx_head_errors,
  input wire i_rx_fifo_error,
  input wire i_rx_bit_tick,
  input wire i_rx_xoff_det,
  input wire i_rx_xon_det,
  input wire i_rx_special_det,
  // transmitter side
  input wire [7:0] i_tx_fifo_level,
  input wire i_tx_shift_empty,
  // modem side
  input wire [3:0] i_modem_deltas,
  input wire i_cts_flow_pin,
  input wire i_rts_flow_pin,
  // outputs
  output reg [7:0] o_line_status_flags,
  output wire o_irq,
  output reg [7:0] o_global_src,
  output wire o_fifo_mode,
  output reg [7:0] o_stop_char_first,
  output reg [7:0] o_stop_char_second,
  output reg [7:0] o_resume_char_first,
  output reg [7:0] o_resume_char_second,
  output reg [7:0] o_rx_trigger_level_set
);

  // ----------------------------------------
  // register strobes
  // ----------------------------------------
  wire rd_rhr = i_rd && (i_addr == `UCIL_ADDR_RHR);
  wire rd_isr = i_rd && (i_addr == `UCIL_ADDR_ISR);
  wire rd_lsr = i_rd && (i_addr == `UCIL_ADDR_LSR);
  wire rd_msr = i_rd && (i_addr == `UCIL_ADDR_MSR);
  wire rd_xch = i_rd && (i_addr == `UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS);
  wire wr_thr = i_wr && (i_addr == `UCIL_ADDR_RHR);
  wire wr_ier = i_wr && (i_addr == `UCIL_ADDR_IER);
  wire wr_fcr = i_wr && (i_addr == `UCIL_ADDR_FCR);
  wire unlock = i_enhanced_function_control[`UCIL_EFR_UNLOCK];

  reg [7:0] ier_q;
  reg fifo_en_q;
  reg rx_ready_q;
  reg [1:0] flow_char_detect_flags_q;
  reg lsr_int_q;
  reg rxto_q;
  reg transmit_ready_event_q;
  reg flow_char_detect_flags_int_q;
  reg special_q;
  reg flow_int_q;
  reg cts_prev_q;
  reg rts_prev_q;
  reg [9:0] to_cnt_q;
  reg tx_was_empty_q;
  reg [5:0] code_q;

  // low-to-high on the chosen pin while that automatic mode runs or its ier bit (7 for cts, 6 for rts) is set
  wire cts_rise = i_cts_flow_pin && !cts_prev_q;
  wire rts_rise = i_rts_flow_pin && !rts_prev_q;
  wire flow_rise = (cts_rise && (i_enhanced_function_control[`UCIL_EFR_AUTO_CTS] || ier_q[7])) ||
                   (rts_rise && (i_enhanced_function_control[`UCIL_EFR_AUTO_RTS] || ier_q[6]));

  // ----------------------------------------
  // enable, fifo control and flow character registers
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      ier_q <= `UCIL_IER_RST;
      fifo_en_q <= 1'b0;
      o_stop_char_first <= `UCIL_CHAR_RST;
      o_stop_char_second <= `UCIL_CHAR_RST;
      o_resume_char_first <= `UCIL_CHAR_RST;
      o_resume_char_second <= `UCIL_CHAR_RST;
      o_rx_trigger_level_set <= `UCIL_TRG_RST;
    end else if (i_ce) begin
      if (wr_ier) begin
        ier_q[3:0] <= i_wdata[3:0];
        ier_q[4] <= 1'b0; // reserved
        if (unlock) begin
          ier_q[7:5] <= i_wdata[7:5];
        end
      end
      // fifo mode follows bit 0; the other fcr bits live in the lower map and are gated there
      if (wr_fcr) begin
        fifo_en_q <= i_wdata[`UCIL_FCR_ENABLE];
      end
      if (i_wr && i_addr == `UCIL_ADDR_RX_FIFO_LEVEL_COUNT) begin
        o_rx_trigger_level_set <= i_wdata;
      end
      if (i_wr && i_addr == `UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS) begin
        o_stop_char_first <= i_wdata;
      end
      if (i_wr && i_addr == `UCIL_ADDR_STOP_CHAR_SECOND) begin
        o_stop_char_second <= i_wdata;
      end
      if (i_wr && i_addr == `UCIL_ADDR_RESUME_CHAR_FIRST) begin
        o_resume_char_first <= i_wdata;
      end
      if (i_wr && i_addr == `UCIL_ADDR_RESUME_CHAR_SECOND) begin
        o_resume_char_second <= i_wdata;
      end
    end
  end
  assign o_fifo_mode = fifo_en_q;

  // ----------------------------------------
  // level sources
  // ----------------------------------------
  wire rx_empty = (i_rx_fifo_level == 8'h00);
  // non-fifo mode: one held character is enough
  wire rx_at_trg = fifo_en_q ? (i_rx_fifo_level >= i_rx_trigger_level) : !rx_empty;
  wire tx_empty = (i_tx_fifo_level == 8'h00);
  wire tx_all_empty = tx_empty && i_tx_shift_empty;
  wire tx_below = fifo_en_q ? (i_tx_fifo_level < i_tx_trigger_level) : tx_empty;
  wire tx_cond = i_auto_rs485 ? tx_all_empty : (tx_below || tx_empty);
  wire line_err = i_rx_overrun || (|i_rx_head_errors);

  // time-out span in bit ticks: 4 chars plus 12 bits
  wire [9:0] to_span = `UCIL_TO_CHARS * {6'h00, i_bit_clk_per_char} + `UCIL_TO_BITS;

  // ----------------------------------------
  // sticky sources; a set always wins over a clear in the same cycle
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_ready_q <= 1'b0;
      lsr_int_q <= 1'b0;
      rxto_q <= 1'b0;
      transmit_ready_event_q <= 1'b0;
      flow_char_detect_flags_int_q <= 1'b0;
      special_q <= 1'b0;
      flow_int_q <= 1'b0;
      flow_char_detect_flags_q <= 2'b00;
      cts_prev_q <= 1'b0;
      rts_prev_q <= 1'b0;
      to_cnt_q <= 10'h000;
      tx_was_empty_q <= 1'b1;
    end else if (i_ce) begin
      // data ready: set on entry, cleared only when empty
      if (i_rx_char_in) begin
        rx_ready_q <= 1'b1;
      end else if (rx_empty) begin
        rx_ready_q <= 1'b0;
      end
      if (i_rx_char_in && line_err) begin
        lsr_int_q <= 1'b1;
      end else if (rd_lsr) begin
        lsr_int_q <= 1'b0;
      end
      // time-out counter restarts on a received character, an rhr read or an empty fifo
      if (i_rx_char_in || rd_rhr || rx_empty) begin
        to_cnt_q <= 10'h000;
      end else if (i_rx_bit_tick && to_cnt_q != to_span) begin
        to_cnt_q <= to_cnt_q + 10'h001;
      end
      if (!rx_empty && i_rx_bit_tick && to_cnt_q + 10'h001 == to_span) begin
        rxto_q <= 1'b1;
      end else if (rd_rhr) begin
        rxto_q <= 1'b0;
      end
      // tx ready is an edge event, so a status read really clears it
      tx_was_empty_q <= tx_cond;
      if (tx_cond && !tx_was_empty_q) begin
        transmit_ready_event_q <= 1'b1;
      end else if (rd_isr && ier_q[1] && code_q == `UCIL_CODE_TRANSMIT_READY_EVENT) begin
        transmit_ready_event_q <= 1'b0;
      end else if (wr_thr) begin
        transmit_ready_event_q <= 1'b0;
      end
      if (i_rx_xoff_det) begin
        flow_char_detect_flags_int_q <= 1'b1;
      end else if (i_rx_xon_det || (rd_isr && code_q == `UCIL_CODE_FLOW_CHAR_DETECT_FLAGS)) begin
        flow_char_detect_flags_int_q <= 1'b0;
      end
      if (i_rx_special_det) begin
        special_q <= 1'b1;
      end else if (i_rx_char_in || (rd_isr && code_q == `UCIL_CODE_FLOW_CHAR_DETECT_FLAGS)) begin
        special_q <= 1'b0;
      end
      // detect flags for the read-clear register
      if (i_rx_xoff_det || i_rx_xon_det) begin
        flow_char_detect_flags_q <= flow_char_detect_flags_q | {i_rx_xon_det, i_rx_xoff_det};
      end else if (rd_xch) begin
        flow_char_detect_flags_q <= 2'b00;
      end
      cts_prev_q <= i_cts_flow_pin;
      rts_prev_q <= i_rts_flow_pin;
      if (flow_rise) begin
        flow_int_q <= 1'b1;
      end else if (rd_msr) begin
        flow_int_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // priority encoder
  // ----------------------------------------
  // sources stay latched underneath the one shown
  wire p_lsr = ier_q[2] && lsr_int_q;
  wire p_rx = ier_q[0] && rx_at_trg;
  wire p_to = ier_q[0] && rxto_q;
  wire p_tx = ier_q[1] && transmit_ready_event_q;
  wire p_msr = ier_q[3] && (|i_modem_deltas);
  wire p_xc = ier_q[5] && (flow_char_detect_flags_int_q || special_q);
  wire p_fl = (ier_q[6] || ier_q[7]) && flow_int_q;
  reg [5:0] code_d;

  // polled mode falls out: with ier[3:0] and ier[7:5] clear nothing reaches the code
  always @* begin
    if (p_lsr) begin
      code_d = `UCIL_CODE_LSR;
    end else if (p_rx) begin
      code_d = `UCIL_CODE_RECEIVE_READY_EVENT;
    end else if (p_to) begin
      code_d = `UCIL_CODE_RXTO;
    end else if (p_tx) begin
      code_d = `UCIL_CODE_TRANSMIT_READY_EVENT;
    end else if (p_msr) begin
      code_d = `UCIL_CODE_MSR;
    end else if (p_xc) begin
      code_d = `UCIL_CODE_FLOW_CHAR_DETECT_FLAGS;
    end else if (p_fl) begin
      code_d = `UCIL_CODE_FLOW;
    end else begin
      code_d = `UCIL_CODE_NONE;
    end
  end

  // code frozen during a status read so the read and its clear agree
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      code_q <= `UCIL_CODE_NONE;
      o_global_src <= 8'h00;
    end else if (i_ce) begin
      if (!rd_isr) begin
        code_q <= code_d;
      end
      o_global_src <= {p_fl, p_xc, p_msr, p_tx, p_to, p_rx, p_lsr, code_d != `UCIL_CODE_NONE};
    end
  end
  assign o_irq = !code_q[0];

  // ----------------------------------------
  // line status and read data
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_line_status_flags <= 8'h60;
    end else if (i_ce) begin
      o_line_status_flags <= {i_rx_fifo_error, tx_all_empty, tx_empty, i_rx_head_errors,
                              i_rx_overrun, rx_ready_q};
    end
  end

  always @* begin
    case (i_addr)
      `UCIL_ADDR_IER: o_rdata = ier_q;
      `UCIL_ADDR_ISR: o_rdata = {fifo_en_q, fifo_en_q, code_q};
      `UCIL_ADDR_LSR: o_rdata = o_line_status_flags;
      `UCIL_ADDR_RX_FIFO_LEVEL_COUNT: o_rdata = i_rx_fifo_level;
      `UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS: o_rdata = {6'h00, flow_char_detect_flags_q};
      default: o_rdata = 8'h00;
    endcase
  end

endmodule // ucil_chan_int

// ---- tb/ucil_host_model.sv ----
// host bus model: byte register reads and writes on the channel port
// assumes: one-cycle strobes taken at the rising edge, read data combinational
`timescale 1ns/100ps
module ucil_host_model (
  // register bus
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // idle edge before each access keeps strobes single-cycle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wdata <= ~v;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    v = i_rdata;
    o_rd <= 1'b0;
  endtask
endmodule // ucil_host_model

// ---- tb/ucil_chan_int_assertions.sv ----
// checker for the channel interrupt block, bound to its ports
// assumes: clock enable held high; single clock domain
`timescale 1ns/100ps
`include "ucil_defines.vh"
module ucil_chk (
  // watched ports
  input wire i_clk_sys,
  input wire i_srst,
  input wire [3:0] i_addr,
  input wire i_rd,
  input wire i_rx_char_in,
  input wire [7:0] i_rx_fifo_level,
  input wire [7:0] i_rx_trigger_level,
  input wire [7:0] i_tx_fifo_level,
  input wire i_tx_shift_empty,
  input wire [7:0] o_rdata,
  input wire [7:0] o_line_status_flags,
  input wire o_irq,
  input wire o_fifo_mode
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  wire isr_rd = i_rd && i_addr == `UCIL_ADDR_ISR;
  property p_isr_any; isr_rd |-> o_rdata[0] == !o_irq; endproperty
  a_isr_any: assert property (p_isr_any) else $error("isr bit0 vs irq");
  property p_isr_fifo; isr_rd |-> o_rdata[7:6] == {2{o_fifo_mode}}; endproperty
  a_isr_fifo: assert property (p_isr_fifo) else $error("isr fifo bits");
  property p_isr_code; isr_rd |-> o_rdata[5:0] inside {6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
  endproperty
  a_isr_code: assert property (p_isr_code) else $error("isr code");
  property p_ier_rsv; i_rd && i_addr == `UCIL_ADDR_IER |-> !o_rdata[4]; endproperty
  a_ier_rsv: assert property (p_ier_rsv) else $error("ier bit4");
  property p_rst; disable iff (1'b0) i_srst |=> !o_irq && o_line_status_flags == 8'h60; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_ready; i_rx_char_in |-> ##2 o_line_status_flags[0]; endproperty
  a_ready: assert property (p_ready) else $error("data ready");
  property p_tx_emp; 1'b1 |=> o_line_status_flags[6] == $past(i_tx_fifo_level == 8'h00 && i_tx_shift_empty);
  endproperty
  a_tx_emp: assert property (p_tx_emp) else $error("tx empty flag");
  // in fifo mode, rx ready code only with the level at or over the trigger
  property p_rx_lvl; isr_rd && o_fifo_mode && o_rdata[5:0] == 6'h04 |->
    $past(i_rx_fifo_level) >= $past(i_rx_trigger_level); endproperty
  a_rx_lvl: assert property (p_rx_lvl) else $error("rx ready level");
  c_to: cover property (isr_rd && o_rdata[5:0] == 6'h0C);
  c_flow: cover property (isr_rd && o_rdata[5:0] == 6'h20);
  c_lsr: cover property (isr_rd && o_rdata[5:0] == 6'h06);
endmodule // ucil_chk
bind ucil_chan_int ucil_chk i_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_rd(i_rd),
  .i_rx_char_in(i_rx_char_in), .i_rx_fifo_level(i_rx_fifo_level), .i_rx_trigger_level(i_rx_trigger_level),
  .i_tx_fifo_level(i_tx_fifo_level), .i_tx_shift_empty(i_tx_shift_empty), .o_rdata(o_rdata),
  .o_line_status_flags(o_line_status_flags), .o_irq(o_irq), .o_fifo_mode(o_fifo_mode));

// ---- tb/ucil_chan_int_tb.sv ----
// self-checking bench for the channel interrupt logic
// assumes: host model drives the register port, bench drives far-side levels
`timescale 1ns/100ps
`include "ucil_defines.vh"
module ucil_chan_int_tb;
  logic clk, srst, ci, ovr, ferr, tk, xoff, xon, spc, cts, rts, she, irq, fm, rd, hwr, rs4;
  logic [3:0] addr, dlt;
  logic [2:0] herr;
  logic [7:0] wd, rdat, enhanced_function_control, modem_control, rtrg, rlvl, tlvl, line_status_flags, gs, s1, s2, r1, r2, ts, d;
  integer num_errors = 0;
  integer n_tests = 0;
  ucil_chan_int i_dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wd), .i_wr(hwr),
    .i_rd(rd), .o_rdata(rdat), .i_enhanced_function_control(enhanced_function_control), .i_modem_control(modem_control), .i_auto_rs485(rs4),
    .i_rx_trigger_level(rtrg), .i_tx_trigger_level(8'h08), .i_bit_clk_per_char(4'hA), .i_rx_fifo_level(rlvl),
    .i_rx_char_in(ci), .i_rx_overrun(ovr), .i_rx_head_errors(herr), .i_rx_fifo_error(ferr), .i_rx_bit_tick(tk),
    .i_rx_xoff_det(xoff), .i_rx_xon_det(xon), .i_rx_special_det(spc), .i_tx_fifo_level(tlvl),
    .i_tx_shift_empty(she), .i_modem_deltas(dlt), .i_cts_flow_pin(cts), .i_rts_flow_pin(rts),
    .o_line_status_flags(line_status_flags), .o_irq(irq), .o_global_src(gs), .o_fifo_mode(fm), .o_stop_char_first(s1),
    .o_stop_char_second(s2), .o_resume_char_first(r1), .o_resume_char_second(r2), .o_rx_trigger_level_set(ts));
  ucil_host_model i_host (.i_clk_sys(clk), .i_rdata(rdat), .o_addr(addr), .o_wdata(wd), .o_wr(hwr), .o_rd(rd));
  // ------
  // helpers
  // ------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    i_host.rd_reg(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask
  task automatic interrupt_source_code(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    rchk(`UCIL_ADDR_ISR, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_host.wr_reg(a, v);
  endtask
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    interrupt_source_code(8'h01);
    rchk(`UCIL_ADDR_IER, 8'h00);
    chk("lsr", 8'h60, line_status_flags);
    rchk(4'h3, 8'h00);
  endtask
  task automatic t_regs;
    wr(`UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS, 8'h13);
    wr(`UCIL_ADDR_STOP_CHAR_SECOND, 8'h93);
    wr(`UCIL_ADDR_RESUME_CHAR_FIRST, 8'h11);
    wr(`UCIL_ADDR_RESUME_CHAR_SECOND, 8'h91);
    wr(`UCIL_ADDR_RX_FIFO_LEVEL_COUNT, 8'h04);
    wr(`UCIL_ADDR_FCR, 8'h01);
    rlvl <= 8'h2A;
    chk("stop1", 8'h13, s1);
    chk("stop2", 8'h93, s2);
    chk("res1", 8'h11, r1);
    chk("res2", 8'h91, r2);
    chk("trg", 8'h04, ts);
    rchk(`UCIL_ADDR_RX_FIFO_LEVEL_COUNT, 8'h2A);
    chk("fifo", 8'h01, {7'h00, fm});
    rlvl <= 8'h03;
  endtask
  task automatic t_rx;
    wr(`UCIL_ADDR_IER, 8'h01);
    interrupt_source_code(8'hC1);
    rlvl <= 8'h04;
    interrupt_source_code(8'hC4);
    chk("irq", 8'h01, {7'h00, irq});
    rlvl <= 8'h03;
    interrupt_source_code(8'hC1);
    rlvl <= 8'h00;
  endtask
  task automatic t_lock;
    wr(`UCIL_ADDR_IER, 8'hFF);
    rchk(`UCIL_ADDR_IER, 8'h0F);
    enhanced_function_control <= 8'h10;
    wr(`UCIL_ADDR_IER, 8'hFF);
    rchk(`UCIL_ADDR_IER, 8'hEF);
    wr(`UCIL_ADDR_IER, 8'h00);
    interrupt_source_code(8'hC1);
  endtask
  task automatic t_prio;
    wr(`UCIL_ADDR_IER, 8'h0F);
    tlvl <= 8'h0A;
    she <= 1'b0;
    repeat (2) @(posedge clk);
    tlvl <= 8'h00;
    she <= 1'b1;
    dlt <= 4'h1;
    herr <= 3'h1;
    ferr <= 1'b1;
    ci <= 1'b1;
    @(posedge clk);
    ci <= 1'b0;
    herr <= 3'h0;
    interrupt_source_code(8'hC6);
    chk("lsr7", 8'h80, line_status_flags & 8'h80);
    i_host.rd_reg(`UCIL_ADDR_LSR, d);
    interrupt_source_code(8'hC2);
    interrupt_source_code(8'hC0);
    dlt <= 4'h0;
    ferr <= 1'b0;
    i_host.rd_reg(`UCIL_ADDR_MSR, d);
    interrupt_source_code(8'hC1);
  endtask
  task automatic t_tmo;
    wr(`UCIL_ADDR_IER, 8'h01);
    rlvl <= 8'h01;
    repeat (53) begin
      @(posedge clk) tk <= 1'b1;
      @(posedge clk) tk <= 1'b0;
    end
    interrupt_source_code(8'hCC);
    i_host.rd_reg(`UCIL_ADDR_RHR, d);
    interrupt_source_code(8'hC1);
    rlvl <= 8'h00;
  endtask
  task automatic t_flow;
    wr(`UCIL_ADDR_IER, 8'hE0);
    modem_control <= 8'h04;
    @(posedge clk) xoff <= 1'b1;
    @(posedge clk) xoff <= 1'b0;
    interrupt_source_code(8'hD0);
    chk("gsrc", 8'h01, {7'h00, gs[0]});
    interrupt_source_code(8'hC1);
    rchk(`UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS, 8'h01);
    rchk(`UCIL_ADDR_FLOW_CHAR_DETECT_FLAGS, 8'h00);
    @(posedge clk) spc <= 1'b1;
    @(posedge clk) spc <= 1'b0;
    @(posedge clk) ci <= 1'b1;
    @(posedge clk) ci <= 1'b0;
    interrupt_source_code(8'hC1);
    enhanced_function_control <= 8'h90;
    cts <= 1'b1;
    interrupt_source_code(8'hE0);
    i_host.rd_reg(`UCIL_ADDR_MSR, d);
    interrupt_source_code(8'hC1);
    enhanced_function_control <= 8'h50;
    rts <= 1'b1;
    interrupt_source_code(8'hE0);
  endtask
  task automatic t_rs485;
    wr(`UCIL_ADDR_IER, 8'h02);
    tlvl <= 8'h01;
    she <= 1'b0;
    rs4 <= 1'b1;
    repeat (2) @(posedge clk);
    tlvl <= 8'h00;
    interrupt_source_code(8'hC1);
    she <= 1'b1;
    interrupt_source_code(8'hC2);
    wr(`UCIL_ADDR_RHR, 8'h55);
    interrupt_source_code(8'hC1);
    rs4 <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  initial begin
    {srst, ci, ovr, ferr, tk, xoff, xon, spc, cts, rts, she} = 11'h401;
    rs4 = 1'b0;
    {dlt, herr, enhanced_function_control, modem_control, rtrg, rlvl, tlvl} = {7'h00, 16'h0000, 8'h04, 16'h0000};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_regs;
    rtrg <= 8'h04;
    t_rx;
    t_lock;
    t_prio;
    t_tmo;
    t_flow;
    t_rs485;
    test_done;
  end
endmodule // ucil_chan_int_tb
